// file: rtl/msc_stat_counters.sv
`timescale 1ns/1ps
module msc_stat_counters (
	clk,
	rst_n,
	frameEvt,
	partialEvt,
	ovrEvt,
	wb_adr_i,
	wb_dat_i,
	wb_sel_i,
	wb_we_i,
	wb_cyc_i,
	wb_stb_i,
	wb_dat_o,
	wb_ack_o,
	wb_err_o,
	irq
);
	import msc_pkg::*;
	input wire logic clk;
	input wire logic rst_n;
	input wire msc_pkg::msc_frame_t frameEvt;
	input wire msc_pkg::msc_bytes_t partialEvt;
	input wire msc_pkg::msc_ovr_t ovrEvt;
	input wire logic [7:0] wb_adr_i;
	input wire logic [31:0] wb_dat_i;
	input wire logic [3:0] wb_sel_i;
	input wire logic wb_we_i;
	input wire logic wb_cyc_i;
	input wire logic wb_stb_i;
	output logic [31:0] wb_dat_o;
	output logic wb_ack_o;
	output logic wb_err_o;
	output logic irq;

	logic [MSC_CNT_W-1:0] bucket_r;
	logic [MSC_CNT_W-1:0] bytes_r;
	logic [MSC_CNT_W-1:0] sof_r;
	logic [MSC_CNT_W-1:0] mof_r;
	logic [MSC_CNT_W-1:0] dma_r;
	logic [MSC_LEN_W-1:0] maxLen_r;
	logic [MSC_ST_W-1:0] status_r;
	logic [MSC_ST_W-1:0] mask_r;
	logic [MSC_CNT_W-1:0] pause_r;
	logic [MSC_ST_W-1:0] evt;
	logic [MSC_LEN_W-1:0] frameLen;
	logic bucketHit;
	logic [MSC_CNT_W:0] byteSum;
	logic req;
	logic mapped;
	logic [31:0] rdData;
	logic rdStatus;
	logic [MSC_LEN_W-1:0] frameBytes;
	logic [MSC_LEN_W-1:0] partBytes;
	logic ovrTake;

	// Pause frames are always reported at their fixed multicast length.
	assign frameLen = frameEvt.isPause ? MSC_PAUSE_LEN : frameEvt.length;
	// Error bits other than collision, underrun and carrier are not inputs at all, so they cannot gate.
	assign bucketHit = frameEvt.valid && !frameEvt.lateColl && !frameEvt.excessColl && !frameEvt.underrun
		&& !frameEvt.carrierErr && frameLen >= MSC_BUCKET_MIN && frameLen <= maxLen_r;
	// Both byte sources can land in one cycle, so they are summed rather than chosen.
	assign frameBytes = frameEvt.valid ? frameLen : 16'h0000;
	assign partBytes = partialEvt.valid ? partialEvt.bytes : 16'h0000;
	assign byteSum = {1'b0, bytes_r} + {17'h00000, frameBytes} + {17'h00000, partBytes};

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bucket_r <= '0;
			bytes_r <= '0;
		end else begin
			if (bucketHit) begin
				bucket_r <= bucket_r + 32'h00000001;
			end
			bytes_r <= byteSum[MSC_CNT_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sof_r <= '0;
			mof_r <= '0;
			dma_r <= '0;
		end else if (ovrTake) begin
			if (ovrEvt.sofOverrun) begin
				sof_r <= sof_r + 32'h00000001;
			end
			if (ovrEvt.mofOverrun && !ovrEvt.sofOverrun) begin
				mof_r <= mof_r + 32'h00000001;
			end
			if (ovrEvt.dmaOverrun) begin
				dma_r <= dma_r + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pause_r <= '0;
		end else if (frameEvt.valid && frameEvt.isPause) begin
			pause_r <= pause_r + 32'h00000001;
		end
	end

	assign evt[MSC_ST_BUCKET] = bucketHit;
	assign ovrTake = ovrEvt.valid && ovrEvt.accepted;
	assign evt[MSC_ST_SOF] = ovrTake && ovrEvt.sofOverrun;
	assign evt[MSC_ST_MOF] = ovrTake && ovrEvt.mofOverrun && !ovrEvt.sofOverrun;
	assign evt[MSC_ST_DMA] = ovrTake && ovrEvt.dmaOverrun;
	assign evt[MSC_ST_WRAP] = byteSum[MSC_CNT_W];

	assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
	assign mapped = wb_adr_i <= MSC_OFF_PAUSE && wb_adr_i[1:0] == 2'b00;
	assign rdStatus = req && mapped && !wb_we_i && wb_adr_i == MSC_OFF_STATUS;

	always_comb begin
		rdData = 32'h00000000;
		unique case (wb_adr_i)
			MSC_OFF_BUCKET: rdData = bucket_r;
			MSC_OFF_BYTES: rdData = bytes_r;
			MSC_OFF_SOF: rdData = sof_r;
			MSC_OFF_MOF: rdData = mof_r;
			MSC_OFF_DMA: rdData = dma_r;
			MSC_OFF_MAXLEN: rdData = {16'h0000, maxLen_r};
			MSC_OFF_STATUS: rdData = {27'h0000000, status_r};
			MSC_OFF_MASK: rdData = {27'h0000000, mask_r};
			MSC_OFF_PAUSE: rdData = pause_r;
			default: rdData = 32'h00000000;
		endcase
	end

	// A read clears the status, but an event in the same cycle still sets its bit.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_r <= '0;
		end else begin
			status_r <= (rdStatus ? '0 : status_r) | evt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			maxLen_r <= MSC_MAXLEN_RST;
			mask_r <= '0;
		end else if (req && mapped && wb_we_i) begin
			if (wb_adr_i == MSC_OFF_MAXLEN) begin
				if (wb_sel_i[0]) begin
					maxLen_r[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					maxLen_r[15:8] <= wb_dat_i[15:8];
				end
			end
			if (wb_adr_i == MSC_OFF_MASK && wb_sel_i[0]) begin
				mask_r <= wb_dat_i[MSC_ST_W-1:0];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req && mapped;
			wb_err_o <= req && !mapped;
			wb_dat_o <= (req && mapped && !wb_we_i) ? rdData : 32'h00000000;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((rdStatus ? '0 : status_r) | evt) & mask_r);
		end
	end

	a_bucket_count: assert property (@(posedge clk) disable iff (!rst_n)
		bucketHit |=> bucket_r == $past(bucket_r) + 32'h00000001) else $error("bucket missed a frame");
	a_bucket_short: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && frameEvt.length < MSC_BUCKET_MIN && !ovrEvt.valid)
		|=> $stable(bucket_r)) else $error("short frame counted in bucket");
	a_bucket_errs: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.lateColl) |=> bucket_r == $past(bucket_r)) else $error("collided frame counted");
	a_byte_sum: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && !partialEvt.valid)
		|=> bytes_r == $past(bytes_r) + {16'h0000, $past(frameEvt.length)}) else $error("frame bytes wrong");
	a_byte_partial: assert property (@(posedge clk) disable iff (!rst_n)
		(partialEvt.valid && !frameEvt.valid)
		|=> bytes_r == $past(bytes_r) + {16'h0000, $past(partialEvt.bytes)}) else $error("partial bytes wrong");
	a_sof_count: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrTake && ovrEvt.sofOverrun) |=> sof_r == $past(sof_r) + 32'h00000001) else $error("sof missed");
	a_mof_count: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrEvt.valid && ovrEvt.accepted && ovrEvt.mofOverrun && !ovrEvt.sofOverrun)
		|=> mof_r == $past(mof_r) + 32'h00000001) else $error("mof missed");
	a_dma_reject: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrEvt.valid && !ovrEvt.accepted) |=> $stable(dma_r) && $stable(sof_r)) else $error("unaccepted counted");
	a_pause_len: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.isPause && !partialEvt.valid)
		|=> bytes_r == $past(bytes_r) + 32'h00000040) else $error("pause length wrong");
	a_ack_once: assert property (@(posedge clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
	a_bucket_long: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && frameEvt.length > maxLen_r)
		|=> $stable(bucket_r)) else $error("long frame counted in bucket");
	a_bucket_excess: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.excessColl)
		|=> $stable(bucket_r)) else $error("excess collision frame counted");
	a_bucket_under: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.underrun)
		|=> $stable(bucket_r)) else $error("underrun frame counted");
	a_bucket_carrier: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.carrierErr)
		|=> $stable(bucket_r)) else $error("carrier error frame counted");
	a_bucket_edges: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && !frameEvt.lateColl && !frameEvt.excessColl
		&& !frameEvt.underrun && !frameEvt.carrierErr && maxLen_r >= MSC_BUCKET_MIN
		&& (frameEvt.length == MSC_BUCKET_MIN || frameEvt.length == maxLen_r))
		|=> bucket_r == $past(bucket_r) + 32'h00000001) else $error("bucket end missed");
	a_bucket_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!bucketHit
		|=> $stable(bucket_r)) else $error("bucket moved without a frame");
	a_byte_both: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && partialEvt.valid) |=> bytes_r == $past(bytes_r)
		+ {16'h0000, $past(frameEvt.length)} + {16'h0000, $past(partialEvt.bytes)}) else $error("byte sum wrong");
	a_byte_errs: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && !frameEvt.isPause && !partialEvt.valid && (frameEvt.lateColl || frameEvt.underrun))
		|=> bytes_r == $past(bytes_r) + {16'h0000, $past(frameEvt.length)}) else $error("error frame bytes lost");
	a_byte_idle: assert property (@(posedge clk) disable iff (!rst_n)
		(!frameEvt.valid && !partialEvt.valid)
		|=> $stable(bytes_r)) else $error("bytes moved without an event");
	a_mof_after_sof: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrTake && ovrEvt.sofOverrun)
		|=> $stable(mof_r)) else $error("mof counted with sof");
	a_dma_count: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrTake && ovrEvt.dmaOverrun)
		|=> dma_r == $past(dma_r) + 32'h00000001) else $error("dma overrun missed");
	a_ovr_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!ovrEvt.valid
		|=> $stable(sof_r) && $stable(mof_r) && $stable(dma_r)) else $error("overrun moved without a report");
	a_mof_reject: assert property (@(posedge clk) disable iff (!rst_n)
		(ovrEvt.valid && !ovrEvt.accepted)
		|=> $stable(mof_r)) else $error("unaccepted mof counted");
	a_pause_count: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.isPause)
		|=> pause_r == $past(pause_r) + 32'h00000001) else $error("pause frame missed");
	a_pause_bucket: assert property (@(posedge clk) disable iff (!rst_n)
		(frameEvt.valid && frameEvt.isPause)
		|=> $stable(bucket_r)) else $error("pause frame in bucket");
	a_status_set: assert property (@(posedge clk) disable iff (!rst_n)
		(|evt)
		|=> (status_r & $past(evt)) == $past(evt)) else $error("status event lost");
	a_status_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(rdStatus && !(|evt))
		|=> status_r == '0) else $error("status not cleared by read");
	a_status_hold: assert property (@(posedge clk) disable iff (!rst_n)
		!rdStatus
		|=> (status_r & $past(status_r)) == $past(status_r)) else $error("status bit dropped");
	a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
		1'b1
		|=> irq == |(status_r & $past(mask_r))) else $error("irq level wrong");
	a_irq_clear: assert property (@(posedge clk) disable iff (!rst_n)
		(rdStatus && !(|evt))
		|=> !irq) else $error("irq stayed after clear");
	a_ack_mapped: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped)
		|=> wb_ack_o && !wb_err_o) else $error("mapped access not acked");
	a_err_unmapped: assert property (@(posedge clk) disable iff (!rst_n)
		(req && !mapped)
		|=> wb_err_o && !wb_ack_o) else $error("unmapped access not refused");
	a_err_once: assert property (@(posedge clk) disable iff (!rst_n)
		wb_err_o
		|=> !wb_err_o) else $error("err held two cycles");
	a_ack_err_excl: assert property (@(posedge clk) disable iff (!rst_n)
		!(wb_ack_o && wb_err_o)) else $error("ack and err together");
	a_dat_idle: assert property (@(posedge clk) disable iff (!rst_n)
		!wb_ack_o
		|-> wb_dat_o == 32'h00000000) else $error("read data outside ack");
	a_read_bucket: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && !wb_we_i && wb_adr_i == MSC_OFF_BUCKET)
		|=> wb_dat_o == $past(bucket_r)) else $error("bucket read data wrong");
	a_read_pause: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && !wb_we_i && wb_adr_i == MSC_OFF_PAUSE)
		|=> wb_dat_o == $past(pause_r)) else $error("pause read data wrong");
	// A wrap needs four gigabytes of traffic, so only this property and the whole-register status and irq properties watch the flag.
	a_wrap_flag: assert property (@(posedge clk) disable iff (!rst_n)
		byteSum[MSC_CNT_W]
		|=> status_r[MSC_ST_WRAP]) else $error("byte wrap not flagged");
	a_maxlen_write: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && wb_we_i && wb_adr_i == MSC_OFF_MAXLEN && wb_sel_i[1:0] == 2'b11)
		|=> {16'h0000, maxLen_r} == ($past(wb_dat_i) & 32'h0000FFFF)) else $error("max length not written");
	a_maxlen_lane: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && wb_we_i && wb_adr_i == MSC_OFF_MAXLEN && wb_sel_i[1:0] == 2'b01)
		|=> ((maxLen_r ^ $past(maxLen_r)) & 16'hFF00) == 16'h0000) else $error("max length high byte written");
	a_mask_write: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && wb_we_i && wb_adr_i == MSC_OFF_MASK && wb_sel_i[0])
		|=> {27'h0000000, mask_r} == ($past(wb_dat_i) & 32'h0000001F)) else $error("mask not written");
	a_mask_keep: assert property (@(posedge clk) disable iff (!rst_n)
		(req && mapped && wb_we_i && wb_adr_i == MSC_OFF_MASK && !wb_sel_i[0])
		|=> $stable(mask_r)) else $error("mask written without lane");
	a_count_ro: assert property (@(posedge clk) disable iff (!rst_n)
		(req && wb_we_i && wb_adr_i == MSC_OFF_BUCKET && !bucketHit)
		|=> $stable(bucket_r)) else $error("counter written by bus");

	c_bucket: cover property (@(posedge clk) disable iff (!rst_n) bucketHit);
	c_sof_mof: cover property (@(posedge clk) disable iff (!rst_n) evt[MSC_ST_SOF] ##[1:20] evt[MSC_ST_MOF]);
	c_irq: cover property (@(posedge clk) disable iff (!rst_n) $rose(irq));
	c_both_bytes: cover property (@(posedge clk) disable iff (!rst_n) frameEvt.valid && partialEvt.valid);
	c_err: cover property (@(posedge clk) disable iff (!rst_n) wb_err_o);
endmodule

// file: rtl/msc_pkg.sv
package msc_pkg;
	localparam int MSC_CNT_W = 32;
	localparam int MSC_LEN_W = 16;
	localparam logic [7:0] MSC_OFF_BUCKET = 8'h00;
	localparam logic [7:0] MSC_OFF_BYTES = 8'h04;
	localparam logic [7:0] MSC_OFF_SOF = 8'h08;
	localparam logic [7:0] MSC_OFF_MOF = 8'h0C;
	localparam logic [7:0] MSC_OFF_DMA = 8'h10;
	localparam logic [7:0] MSC_OFF_MAXLEN = 8'h14;
	localparam logic [7:0] MSC_OFF_STATUS = 8'h18;
	localparam logic [7:0] MSC_OFF_MASK = 8'h1C;
	localparam logic [7:0] MSC_OFF_PAUSE = 8'h20;
	localparam logic [15:0] MSC_BUCKET_MIN = 16'h0400;
	localparam logic [15:0] MSC_MAXLEN_RST = 16'h05EE;
	localparam logic [15:0] MSC_PAUSE_LEN = 16'h0040;
	localparam int MSC_ST_BUCKET = 0;
	localparam int MSC_ST_SOF = 1;
	localparam int MSC_ST_MOF = 2;
	localparam int MSC_ST_DMA = 3;
	localparam int MSC_ST_WRAP = 4;
	localparam int MSC_ST_W = 5;

	// One finished frame, transmitted or received.
	typedef struct packed {
		logic valid;
		logic isPause;
		logic lateColl;
		logic excessColl;
		logic underrun;
		logic carrierErr;
		logic [15:0] length;
	} msc_frame_t;

	// Partial byte events: bytes before carrier loss, collision or jam.
	typedef struct packed {
		logic valid;
		logic [15:0] bytes;
	} msc_bytes_t;

	// Receive overrun report, counted only when accepted is set.
	typedef struct packed {
		logic valid;
		logic accepted;
		logic sofOverrun;
		logic mofOverrun;
		logic dmaOverrun;
	} msc_ovr_t;
endpackage

// file: tb/msc_phy_model.sv
`timescale 1ns/1ps
module msc_phy_model (
	clk,
	frameEvt,
	partialEvt,
	ovrEvt
);
	import msc_pkg::*;
	input wire logic clk;
	output msc_pkg::msc_frame_t frameEvt;
	output msc_pkg::msc_bytes_t partialEvt;
	output msc_pkg::msc_ovr_t ovrEvt;
	initial begin
		frameEvt = '0;
		partialEvt = '0;
		ovrEvt = '0;
	end
	// A quiet cycle follows each pulse, so a report is never merged with the next one.
	task automatic sendFrame(input logic [4:0] fl, input logic [15:0] len);
		@(posedge clk);
		frameEvt <= {1'b1, fl, len};
		@(posedge clk);
		frameEvt <= '0;
	endtask
	// Jam bytes are never reported here, so they cannot be counted twice.
	task automatic sendPart(input logic [15:0] n);
		@(posedge clk);
		partialEvt <= {1'b1, n};
		@(posedge clk);
		partialEvt <= '0;
	endtask
	task automatic sendOvr(input logic [3:0] o);
		@(posedge clk);
		ovrEvt <= {1'b1, o};
		@(posedge clk);
		ovrEvt <= '0;
	endtask
endmodule

// file: tb/msc_stat_counters_tb.sv
`timescale 1ns/1ps
module msc_stat_counters_tb;
	import msc_pkg::*;
	logic clk;
	logic rst_n;
	msc_frame_t frameEvt;
	msc_bytes_t partialEvt;
	msc_ovr_t ovrEvt;
	logic [7:0] adr;
	logic [31:0] datW;
	logic [31:0] datR;
	logic [3:0] sel;
	logic we;
	logic cyc;
	logic stb;
	logic ack;
	logic err;
	logic irq;
	logic [31:0] rd;
	logic rdErr;
	logic [31:0] expBytes;
	int n_errors;
	int check_count;
	logic [4:0] fl [11] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h08, 5'h04, 5'h02, 5'h01, 5'h10, 5'h00, 5'h00};
	logic [15:0] ln [11] = '{16'h03FF, 16'h0400, 16'h05EE, 16'h05EF, 16'h0400, 16'h0400, 16'h0400, 16'h0400,
		16'h0400, 16'h0500, 16'h0501};
	msc_phy_model phy_u (.clk(clk), .frameEvt(frameEvt), .partialEvt(partialEvt), .ovrEvt(ovrEvt));
	msc_stat_counters dut_u (.clk(clk), .rst_n(rst_n), .frameEvt(frameEvt), .partialEvt(partialEvt),
		.ovrEvt(ovrEvt), .wb_adr_i(adr), .wb_dat_i(datW), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_dat_o(datR), .wb_ack_o(ack), .wb_err_o(err), .irq(irq));
	task automatic wrap_up();
		if (n_errors == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// The answer is taken at the edge that sees ack or err, and the request is released only then.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		int i;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		datW <= d;
		sel <= s;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (ack !== 1'b1 && err !== 1'b1 && i < 20);
		rd = datR;
		rdErr = err;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (i >= 20) begin
			n_errors++;
			wrap_up();
		end
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000, 4'hF);
		chk(rd, exp);
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		rst_n = 1'b0;
		{cyc, stb, we, adr, datW, sel} = '0;
		n_errors = 0;
		check_count = 0;
		expBytes = 32'h00000000;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rdChk(MSC_OFF_MAXLEN, 32'h000005EE);
		wb(1'b1, MSC_OFF_MASK, 32'h00000001, 4'h1);
		for (int k = 0; k < 11; k++) begin
			if (k == 9) wb(1'b1, MSC_OFF_MAXLEN, 32'h00000500, 4'h3);
			phy_u.sendFrame(fl[k], ln[k]);
			expBytes += fl[k][4] ? 32'h00000040 : {16'h0000, ln[k]};
		end
		rdChk(MSC_OFF_BUCKET, 32'h00000003);
		chk({31'h0, irq}, 32'h00000001);
		rdChk(MSC_OFF_STATUS, 32'h00000001);
		chk({31'h0, irq}, 32'h00000000);
		rdChk(MSC_OFF_PAUSE, 32'h00000001);
		phy_u.sendPart(16'h0064);
		phy_u.sendPart(16'h0025);
		phy_u.sendPart(16'h0030);
		fork
			phy_u.sendFrame(5'h00, 16'h0200);
			phy_u.sendPart(16'h0010);
		join
		rdChk(MSC_OFF_BYTES, expBytes + 32'h000002C9);
		phy_u.sendOvr(4'hC);
		phy_u.sendOvr(4'hA);
		phy_u.sendOvr(4'h9);
		phy_u.sendOvr(4'h7);
		phy_u.sendOvr(4'hE);
		rdChk(MSC_OFF_SOF, 32'h00000002);
		rdChk(MSC_OFF_MOF, 32'h00000001);
		rdChk(MSC_OFF_DMA, 32'h00000001);
		chk({31'h0, irq}, 32'h00000000);
		rdChk(MSC_OFF_STATUS, 32'h0000000E);
		wb(1'b1, MSC_OFF_BUCKET, 32'hFFFFFFFF, 4'hF);
		rdChk(MSC_OFF_BUCKET, 32'h00000003);
		wb(1'b0, 8'h24, 32'h00000000, 4'hF);
		chk({31'h0, rdErr}, 32'h00000001);
		wb(1'b1, MSC_OFF_MAXLEN, 32'h0000FF33, 4'h1);
		rdChk(MSC_OFF_MAXLEN, 32'h00000533);
		wb(1'b1, MSC_OFF_MAXLEN, 32'h00000700, 4'h2);
		rdChk(MSC_OFF_MAXLEN, 32'h00000733);
		wb(1'b1, MSC_OFF_MASK, 32'h00000000, 4'hE);
		rdChk(MSC_OFF_MASK, 32'h00000001);
		phy_u.sendFrame(5'h00, 16'h0733);
		rdChk(MSC_OFF_BUCKET, 32'h00000004);
		chk({31'h0, irq}, 32'h00000001);
		wrap_up();
	end
endmodule
